// ### shared/dfp_pkg.sv
`default_nettype none
package dfp_pkg;
  // widths
  localparam int WORD_W = 16;
  localparam int NUM_OUT = 12;
  localparam int CNT_W = 16;
  localparam int BIT_CNT_W = 4;
  localparam int SYNC_W = 35;

  // control word fields
  localparam int CTL_OVERVOLTAGE_LOCKOUT_EN_BIT = 15;
  localparam int CTL_ULD_BIT = 14;
  localparam int CTL_OCD_BIT = 13;
  localparam int CTL_OUT_MSB = 12;
  localparam int CTL_OUT_LSB = 1;
  localparam int CTL_CLR_BIT = 0;

  // status word fields
  localparam int ST_PSF_BIT = 15;
  localparam int ST_UL_BIT = 14;
  localparam int ST_OL_BIT = 13;
  localparam int ST_TW_BIT = 0;

  // reset values
  localparam logic [WORD_W-1:0] CTL_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [NUM_OUT-1:0] OUT_RESET = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 4'h1;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 35'h000000000;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int OC_SHORT_NS = 25000;
  localparam int OC_LONG_NS = 200000;
  localparam int UL_DELAY_NS = 350000;
  localparam logic [CNT_W-1:0] OC_SHORT_CYC = CNT_W'(OC_SHORT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OC_LONG_CYC = CNT_W'(OC_LONG_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] UL_DELAY_CYC = CNT_W'(UL_DELAY_NS / CLK_PERIOD_NS);

  // serial frame state
  typedef enum logic [0:0] {
    FR_IDLE = 1'b0,
    FR_SHIFT = 1'b1
  } dfp_frame_t;
endpackage : dfp_pkg
`default_nettype wire

// ### sim/dfp_host.sv
`timescale 1ns/1ps
`default_nettype none
module dfp_host (
  // clock
  input wire logic clock_in,
  // serial pins
  output logic spi_clk_out,
  output logic chip_select_n_out,
  output logic spi_mosi_out,
  // serial data returned by the block
  input wire logic miso_in,
  output logic [15:0] miso_word_out
);
  logic [15:0] last_word;

  initial
  begin
    spi_clk_out = 1'h0;
    chip_select_n_out = 1'h1;
    spi_mosi_out = 1'h0;
    last_word = 16'h0000;
    miso_word_out = 16'h0000;
  end

  // frame of nbits, lsb first; clock idle low, data pulled low after
  task automatic send(input logic [15:0] word, input int nbits);
    int i;
    last_word = word & 16'hFFFE;
    @(negedge clock_in);
    chip_select_n_out = 1'h0;
    repeat (10) @(negedge clock_in);
    for (i = 0; i < nbits; i++)
    begin
      spi_mosi_out = word[i];
      spi_clk_out = 1'h1;
      repeat (10) @(negedge clock_in);
      miso_word_out[i] = miso_in;
      spi_clk_out = 1'h0;
      repeat (10) @(negedge clock_in);
    end
    chip_select_n_out = 1'h1;
    spi_mosi_out = 1'h0;
    repeat (10) @(negedge clock_in);
  endtask : send

  // clear resends the outputs and options of the last word sent, whole frame or not
  task automatic clear();
    send(last_word | 16'h0001, 16);
  endtask : clear
endmodule : dfp_host
`default_nettype wire

// ### sim/dfp_protect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dfp_protect_tb;
  import dfp_pkg::*;
  logic clock_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic enable_in = 1'h1;
  logic vcc_ok_in = 1'h1;
  logic tw_in = 1'h0;
  logic tsd_in = 1'h0;
  logic uva_in = 1'h0;
  logic uvb_in = 1'h0;
  logic ova_in = 1'h0;
  logic ovb_in = 1'h0;
  logic [NUM_OUT-1:0] oc_in = 12'h000;
  logic [NUM_OUT-1:0] ul_in = 12'h000;
  wire logic sclk;
  wire logic cs_n;
  wire logic mosi;
  logic miso;
  logic miso_oe_n;
  logic [NUM_OUT-1:0] drv;
  logic [WORD_W-1:0] ctl;
  logic [WORD_W-1:0] st;
  logic [31:0] exp_q[$];
  event obs_ev;
  int err_total = 0;
  int cmp_count = 0;
  logic [15:0] seed = 16'h3868;
  logic [15:0] c;
  logic [11:0] o;
  logic [31:0] want;
  wire logic [15:0] so_word;

  // xorshift source for random control patterns
  function automatic logic [15:0] xorshift(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    t = t ^ (t << 8);
    return t;
  endfunction : xorshift

  always #4 clock_in = ~clock_in;

  dfp_host i_host (.clock_in(clock_in), .spi_clk_out(sclk),
    .chip_select_n_out(cs_n), .spi_mosi_out(mosi), .miso_in(miso),
    .miso_word_out(so_word));

  dfp_protect #(.OC_SHORT_LIMIT(16'h0008), .OC_LONG_LIMIT(16'h0014),
    .UL_LIMIT(16'h001E)) i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .enable_in(enable_in), .vcc_ok_in(vcc_ok_in), .spi_clk_in(sclk),
    .chip_select_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_n_out(miso_oe_n), .thermal_warning_in(tw_in),
    .thermal_shutdown_in(tsd_in), .driver_supply_a_uv_in(uva_in),
    .driver_supply_b_uv_in(uvb_in), .driver_supply_a_ov_in(ova_in),
    .driver_supply_b_ov_in(ovb_in), .overcurrent_in(oc_in),
    .underload_in(ul_in), .driver_output_out(drv),
    .control_word_out(ctl), .status_word_out(st));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // let outputs settle, then note the expected control and status
  task automatic expect_now(input logic [15:0] cw, input logic [15:0] sw);
    repeat (8) @(negedge clock_in);
    exp_q.push_back({cw, sw});
    ->obs_ev;
  endtask : expect_now

  task automatic cycles(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cycles

  initial
  begin
    forever
    begin
      @(obs_ev);
      want = exp_q.pop_front();
      chk({ctl, st}, want);
      chk({20'h00000, drv}, {20'h00000, want[12:1]});
      chk({31'h00000000, miso_oe_n}, 32'h00000001);
    end
  end

  initial
  begin
    cycles(100000);
    err_total++;
    wrap_up();
  end

  initial
  begin
    cycles(4);
    rst_n_in = 1'h1;
    cycles(4);
    expect_now(16'h0000, 16'h0000);
    seed = xorshift(seed);
    o = seed[11:0] | 12'h111;
    c = {3'h2, o, 1'h0};
    i_host.send(c, 16);
    expect_now(c, {3'h0, o, 1'h0});
    i_host.send(16'hFFFF, 15);
    expect_now(c, {3'h0, o, 1'h0});
    oc_in = 12'h001;
    cycles(14);
    oc_in = 12'h000;
    expect_now(c, {3'h0, o, 1'h0});
    c[13] = 1'h1;
    i_host.send(c, 16);
    tw_in = 1'h1;
    oc_in = 12'h001;
    cycles(16);
    tw_in = 1'h0;
    oc_in = 12'h000;
    expect_now(c, {3'h1, o & 12'hFFE, 1'h1});
    oc_in = 12'h001;
    i_host.clear();
    chk({16'h0000, so_word}, {16'h0000, 3'h1, o & 12'hFFE, 1'h1});
    expect_now(c, {3'h1, o & 12'hFFE, 1'h0});
    oc_in = 12'h000;
    i_host.clear();
    expect_now(c, {3'h0, o, 1'h0});
    ul_in = 12'h010;
    cycles(20);
    ul_in = 12'h110;
    cycles(16);
    ul_in = 12'h000;
    expect_now(c, {3'h2, o & 12'hEEF, 1'h0});
    c[14] = 1'h0;
    i_host.send(c | 16'h0001, 16);
    ul_in = 12'h010;
    cycles(40);
    ul_in = 12'h000;
    expect_now(c, {3'h2, o, 1'h0});
    i_host.clear();
    uva_in = 1'h1;
    expect_now(c, {3'h4, 12'h000, 1'h0});
    uva_in = 1'h0;
    expect_now(c, {3'h4, o, 1'h0});
    i_host.clear();
    ovb_in = 1'h1;
    expect_now(c, {3'h4, o, 1'h0});
    c[15] = 1'h1;
    i_host.send(c, 16);
    expect_now(c, {3'h4, 12'h000, 1'h0});
    ovb_in = 1'h0;
    i_host.clear();
    tsd_in = 1'h1;
    expect_now(c, {3'h0, 12'h000, 1'h0});
    tsd_in = 1'h0;
    expect_now(c, {3'h0, o, 1'h0});
    enable_in = 1'h0;
    cycles(4);
    enable_in = 1'h1;
    expect_now(16'h0000, 16'h0000);
    vcc_ok_in = 1'h0;
    i_host.send(c, 16);
    expect_now(16'h0000, 16'h0000);
    vcc_ok_in = 1'h1;
    cycles(4);
    wrap_up();
  end
endmodule : dfp_protect_tb
`default_nettype wire

// ### src/dfp_protect.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1 - status clear empties all fault flags and releases latched-off outputs
// RULE2 - status clear acts at chip select rising edge ending its frame
// RULE3 - host resends previous output and option bits with the clear bit
// RULE4 - a fault still present after clear is detected and latched again
// RULE5 - enable toggle or logic supply power-on reset returns logic to reset
// RULE6 - enable low means sleep, all control and status bits lost
// RULE7 - at power-up all twelve drivers start off
// RULE8 - serial commands accepted only with logic supply above lockout
// RULE9 - supply undervoltage or locked overvoltage forces drivers off, keeps data
// RULE10 - persistent overcurrent latches output off and sets overload flag
// RULE11 - control bit 13 picks 25 us or 200 us overcurrent delay
// RULE12 - a running overcurrent delay keeps the select value from its start
// RULE13 - under-load beyond delay on enabled output sets sticky flag bit 14
// RULE14 - under-load timeout latches driver off only when control bit 14 set
// RULE15 - one global under-load timer serves all channels
// RULE16 - global under-load timer keeps running while any under-load persists
// RULE17 - driver supply undervoltage sets bit 15 and turns outputs off
// RULE18 - outputs return to programmed state when supplies recover
// RULE19 - no driver turns on during thermal shutdown
// RULE20 - control word layout: lockout, under-load, delay, outputs, clear
// RULE21 - status word layout: supply fail, under-load, overload, outputs, warning
// RULE22 - only frames of whole multiples of 16 clocks are applied
// RULE23 - overvoltage sets bit 15, drivers off only with lockout enabled
// RULE24 - delays are clock counters with parameter terminal counts
module dfp_protect
  import dfp_pkg::*;
#(
  parameter logic [CNT_W-1:0] OC_SHORT_LIMIT = OC_SHORT_CYC,
  parameter logic [CNT_W-1:0] OC_LONG_LIMIT = OC_LONG_CYC,
  parameter logic [CNT_W-1:0] UL_LIMIT = UL_DELAY_CYC
)
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // power and enable pins
  input wire logic enable_in,
  input wire logic vcc_ok_in,
  // serial port
  input wire logic spi_clk_in,
  input wire logic chip_select_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_n_out,
  // comparator inputs
  input wire logic thermal_warning_in,
  input wire logic thermal_shutdown_in,
  input wire logic driver_supply_a_uv_in,
  input wire logic driver_supply_b_uv_in,
  input wire logic driver_supply_a_ov_in,
  input wire logic driver_supply_b_ov_in,
  input wire logic [NUM_OUT-1:0] overcurrent_in,
  input wire logic [NUM_OUT-1:0] underload_in,
  // driver, control and status outputs
  output logic [NUM_OUT-1:0] driver_output_out,
  output logic [WORD_W-1:0] control_word_out,
  output logic [WORD_W-1:0] status_word_out
);

  // terminal count for a delay select value
  function automatic logic [CNT_W-1:0] dfp_oc_limit(input logic sel);
    dfp_oc_limit = sel ? OC_SHORT_LIMIT : OC_LONG_LIMIT;
  endfunction : dfp_oc_limit

  // input synchronisers
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] raw_pins;

  assign raw_pins = {spi_clk_in, chip_select_n_in, spi_mosi_in, enable_in,
                     vcc_ok_in, thermal_warning_in, thermal_shutdown_in,
                     driver_supply_a_uv_in, driver_supply_b_uv_in,
                     driver_supply_a_ov_in, driver_supply_b_ov_in,
                     overcurrent_in, underload_in};

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end
    else
    begin
      sync1_reg <= raw_pins;
      sync2_reg <= sync1_reg;
    end
  end

  logic sclk_s, cs_n_s, mosi_s, en_s, vcc_s, tw_s, tsd_s;
  logic uva_s, uvb_s, ova_s, ovb_s;
  logic [NUM_OUT-1:0] oc_s;
  logic [NUM_OUT-1:0] ul_s;

  assign {sclk_s, cs_n_s, mosi_s, en_s, vcc_s, tw_s, tsd_s,
          uva_s, uvb_s, ova_s, ovb_s, oc_s, ul_s} = sync2_reg;

  // sleep or logic-supply lockout wipes all state except synchronisers, edge history and delay selects
  logic logic_clear;
  assign logic_clear = ~en_s | ~vcc_s; // see RULE5 see RULE6 see RULE8

  // edge detection on synchronised link signals
  logic sclk_prev_reg;
  logic cs_n_prev_reg;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sclk_prev_reg <= 1'b0;
      cs_n_prev_reg <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= sclk_s;
      cs_n_prev_reg <= cs_n_s;
    end
  end

  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sclk_rise = sclk_s & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_s & sclk_prev_reg;
  assign cs_fall = ~cs_n_s & cs_n_prev_reg;
  assign cs_rise = cs_n_s & ~cs_n_prev_reg;

  // serial frame engine
  dfp_frame_t frame_reg;
  logic [WORD_W-1:0] rx_reg;
  logic [WORD_W-1:0] tx_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic any_bit_reg;
  logic mosi_cap_reg;
  logic [WORD_W-1:0] status_word;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      frame_reg <= FR_IDLE;
      rx_reg <= SHIFT_RESET;
      tx_reg <= SHIFT_RESET;
      bit_cnt_reg <= BIT_CNT_RESET;
      any_bit_reg <= 1'b0;
      mosi_cap_reg <= 1'b0;
    end
    else if (logic_clear)
    begin
      frame_reg <= FR_IDLE;
      rx_reg <= SHIFT_RESET;
      tx_reg <= SHIFT_RESET;
      bit_cnt_reg <= BIT_CNT_RESET;
      any_bit_reg <= 1'b0;
      mosi_cap_reg <= 1'b0;
    end
    else
    begin
      case (frame_reg)
        FR_IDLE:
        begin
          if (cs_fall)
          begin
            frame_reg <= FR_SHIFT;
            tx_reg <= status_word;
            bit_cnt_reg <= BIT_CNT_RESET;
            any_bit_reg <= 1'b0;
          end
        end
        FR_SHIFT:
        begin
          if (cs_rise)
            frame_reg <= FR_IDLE;
          else if (sclk_fall)
          begin
            rx_reg <= {mosi_s, rx_reg[WORD_W-1:1]};
            mosi_cap_reg <= mosi_s;
            bit_cnt_reg <= bit_cnt_reg + BIT_CNT_ONE;
            any_bit_reg <= 1'b1;
          end
          else if (sclk_rise && any_bit_reg)
            tx_reg <= {mosi_cap_reg, tx_reg[WORD_W-1:1]};
        end
        default:
          frame_reg <= FR_IDLE;
      endcase
    end
  end

  assign spi_miso_out = tx_reg[0];
  assign spi_miso_oe_n_out = (frame_reg != FR_SHIFT);

  // frame acceptance and clear request
  logic frame_ok, word_take, clr_now;
  assign frame_ok = any_bit_reg && (bit_cnt_reg == BIT_CNT_RESET); // see RULE22
  assign word_take = (frame_reg == FR_SHIFT) && cs_rise && frame_ok;
  assign clr_now = word_take && rx_reg[CTL_CLR_BIT]; // see RULE2

  logic [WORD_W-1:0] ctl_reg;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ctl_reg <= CTL_RESET;
    else if (logic_clear)
      ctl_reg <= CTL_RESET; // see RULE6
    else if (word_take)
      ctl_reg <= {rx_reg[WORD_W-1:CTL_OUT_LSB], 1'b0}; // see RULE20
  end

  // supply supervision
  logic uv_any, ov_any, supply_off;
  assign uv_any = uva_s | uvb_s;
  assign ov_any = ova_s | ovb_s;
  assign supply_off = uv_any | (ov_any & ctl_reg[CTL_OVERVOLTAGE_LOCKOUT_EN_BIT]); // see RULE23

  // overcurrent delay per channel
  logic [CNT_W-1:0] oc_cnt_reg [NUM_OUT];
  logic [NUM_OUT-1:0] oc_sel_reg;
  logic [NUM_OUT-1:0] oc_active;
  logic [NUM_OUT-1:0] oc_trip;
  logic [NUM_OUT-1:0] drv_reg;

  always_comb
  begin
    for (int i = 0; i < NUM_OUT; i++)
    begin
      oc_active[i] = oc_s[i] & drv_reg[i];
      oc_trip[i] = oc_active[i] && (oc_cnt_reg[i] ==
        dfp_oc_limit((oc_cnt_reg[i] == CNT_RESET) ?
          ctl_reg[CTL_OCD_BIT] : oc_sel_reg[i]) - CNT_ONE); // see RULE11
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NUM_OUT; i++)
        oc_cnt_reg[i] <= CNT_RESET;
      oc_sel_reg <= OUT_RESET;
    end
    else
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        if (logic_clear || !oc_active[i] || oc_trip[i])
          oc_cnt_reg[i] <= CNT_RESET; // see RULE24
        else
        begin
          if (oc_cnt_reg[i] == CNT_RESET)
            oc_sel_reg[i] <= ctl_reg[CTL_OCD_BIT]; // see RULE12
          oc_cnt_reg[i] <= oc_cnt_reg[i] + CNT_ONE;
        end
      end
    end
  end

  // global under-load timer
  logic [CNT_W-1:0] ul_cnt_reg;
  logic [NUM_OUT-1:0] ul_active;
  logic [NUM_OUT-1:0] ul_hit;
  logic ul_expired;

  assign ul_active = ul_s & drv_reg;
  assign ul_expired = (ul_cnt_reg == UL_LIMIT - CNT_ONE);
  assign ul_hit = ul_active & {NUM_OUT{ul_expired}}; // see RULE15

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ul_cnt_reg <= CNT_RESET;
    else if (logic_clear || !(|ul_active))
      ul_cnt_reg <= CNT_RESET;
    else if (!ul_expired)
      ul_cnt_reg <= ul_cnt_reg + CNT_ONE; // see RULE16
  end

  // latched-off outputs, set wins over clear
  logic [NUM_OUT-1:0] latch_off_reg;
  logic [NUM_OUT-1:0] latch_set;
  assign latch_set = oc_trip |
    (ul_hit & {NUM_OUT{ctl_reg[CTL_ULD_BIT]}}); // see RULE10 see RULE14

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      latch_off_reg <= OUT_RESET;
    else if (logic_clear)
      latch_off_reg <= OUT_RESET;
    else
      latch_off_reg <= (clr_now ? OUT_RESET : latch_off_reg) |
        latch_set; // see RULE1 see RULE4
  end

  // sticky fault flags, set wins over clear
  logic supply_fail_flag_reg;
  logic underload_flag_reg;
  logic overload_flag_reg;
  logic thermal_warning_flag_reg;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      supply_fail_flag_reg <= 1'b0;
      underload_flag_reg <= 1'b0;
      overload_flag_reg <= 1'b0;
      thermal_warning_flag_reg <= 1'b0;
    end
    else if (logic_clear)
    begin
      supply_fail_flag_reg <= 1'b0;
      underload_flag_reg <= 1'b0;
      overload_flag_reg <= 1'b0;
      thermal_warning_flag_reg <= 1'b0;
    end
    else
    begin
      supply_fail_flag_reg <= (supply_fail_flag_reg & ~clr_now) |
        uv_any | ov_any; // see RULE1 see RULE17 see RULE23
      underload_flag_reg <= (underload_flag_reg & ~clr_now) |
        (|ul_hit); // see RULE13
      overload_flag_reg <= (overload_flag_reg & ~clr_now) |
        (|oc_trip); // see RULE10
      thermal_warning_flag_reg <= (thermal_warning_flag_reg & ~clr_now) |
        tw_s; // see RULE1
    end
  end

  // driver stage
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      drv_reg <= OUT_RESET; // see RULE7
    else if (logic_clear)
      drv_reg <= OUT_RESET;
    else
      drv_reg <= ctl_reg[CTL_OUT_MSB:CTL_OUT_LSB] & ~latch_off_reg &
        ~{NUM_OUT{tsd_s | supply_off}}; // see RULE9 see RULE18 see RULE19
  end

  assign status_word = {supply_fail_flag_reg, underload_flag_reg,
                        overload_flag_reg, drv_reg,
                        thermal_warning_flag_reg}; // see RULE21
  assign driver_output_out = drv_reg;
  assign control_word_out = ctl_reg;
  assign status_word_out = status_word;

  // checks
  clear_psf_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clr_now && !uv_any && !ov_any && !logic_clear |=> !supply_fail_flag_reg)
    else $error("supply fail flag survived a status clear"); // see RULE1
  clear_at_cs_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clr_now |-> cs_rise && frame_reg == FR_SHIFT)
    else $error("status clear outside frame end"); // see RULE2
  uv_off_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    uv_any |=> drv_reg == OUT_RESET)
    else $error("driver on during undervoltage"); // see RULE17
  sleep_wipe_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    logic_clear |=> ctl_reg == CTL_RESET && status_word == SHIFT_RESET)
    else $error("state kept through sleep"); // see RULE6
  tsd_off_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    tsd_s |=> drv_reg == OUT_RESET)
    else $error("driver on during thermal shutdown"); // see RULE19
  oc_latch_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (|oc_trip) && !logic_clear |=> overload_flag_reg && |latch_off_reg)
    else $error("overcurrent trip not latched"); // see RULE10
  ul_flag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (|ul_hit) && !logic_clear |=> underload_flag_reg)
    else $error("under-load timeout without flag"); // see RULE13
  bad_frame_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    frame_reg == FR_SHIFT && cs_rise && !frame_ok && !logic_clear
      |=> $stable(ctl_reg))
    else $error("partial frame changed control word"); // see RULE22
  ul_keep_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (|ul_hit) && !ctl_reg[CTL_ULD_BIT] && !(|oc_trip) && !clr_now
      && !logic_clear |=> $stable(latch_off_reg))
    else $error("under-load latched output with shutdown off"); // see RULE14

endmodule : dfp_protect
`default_nettype wire
